/* verilog/ncb_host.v */
// Operation
// - read setup, source address, confirm 35h
// - after ready, read bytes or send 85h
// - programming starts only on confirm 10h
// - source and destination share plane bit
// - odd/even page parity should match
// - interrupted program page must not be reused; the code only flags a reset taken in the first idle cycle after a program
// - raised read only after ECC errors seen
// - write 00h before resuming data reads
// - use enhanced status for shared selects
// - enhanced status carries plane and die address
`timescale 1ns/1ns
`include "ncb_map.vh"
module ncb_host (
   // Clock and reset
   input  wire        aclk,
   input  wire        aresetn,
   // AXI4-Lite write channels
   input  wire [4:0]  s_axi_awaddr,
   input  wire        s_axi_awvalid,
   output wire        s_axi_awready,
   input  wire [31:0] s_axi_wdata,
   input  wire [3:0]  s_axi_wstrb,
   input  wire        s_axi_wvalid,
   output wire        s_axi_wready,
   output reg  [1:0]  s_axi_bresp,
   output reg         s_axi_bvalid,
   input  wire        s_axi_bready,
   // AXI4-Lite read channels
   input  wire [4:0]  s_axi_araddr,
   input  wire        s_axi_arvalid,
   output wire        s_axi_arready,
   output reg  [31:0] s_axi_rdata,
   output reg  [1:0]  s_axi_rresp,
   output reg         s_axi_rvalid,
   input  wire        s_axi_rready,
   // Flash pins
   output reg         ce_n,
   output reg         cle,
   output reg         ale,
   output reg         we_n,
   output reg         read_strobe_n,
   output reg         wp_n,
   input  wire        rb_n,
   input  wire [7:0]  io_in,
   output reg  [7:0]  io_out,
   output reg         io_oe
);
   // ****************************************************************
   // Constants
   // ****************************************************************
   localparam [7:0] TWP_C  = `NCB_CYC(`NCB_TWP_NS);  // Write strobe low
   localparam [7:0] TWH_C  = `NCB_CYC(`NCB_TWH_NS);  // Write strobe high
   localparam [7:0] TRP_C  = `NCB_CYC(`NCB_TRP_NS);  // Read strobe low
   localparam [7:0] TREH_C = `NCB_CYC(`NCB_TREH_NS); // Read strobe high
   localparam [7:0] TWB_C  = `NCB_CYC(`NCB_TWB_NS);  // Busy onset delay
   localparam [2:0] K_CMD = 3'h0, K_ADR = 3'h1, K_DAT = 3'h2, K_RD = 3'h3,
                    K_WAIT = 3'h4, K_DONE = 3'h5;
   localparam [2:0] S_IDLE = 3'h0, S_DEC = 3'h1, S_WLO = 3'h2, S_WHI = 3'h3,
                    S_RLO = 3'h4, S_RHI = 3'h5, S_WB = 3'h6, S_WRB = 3'h7;
   localparam [1:0] OKAY = 2'h0, SLVERR = 2'h2;

   // ****************************************************************
   // Registers
   // ****************************************************************
   reg  [2:0]  state_reg;              // Sequencer state
   reg  [3:0]  op_reg;                 // Running operation
   reg  [2:0]  step_reg;               // Step within operation
   reg  [7:0]  ph_reg;                 // Phase counter
   reg  [15:0] col_reg;                // Column address
   reg  [23:0] row_reg;                // Row address
   reg  [23:0] src_row_reg;            // Copy-back source row
   reg  [7:0]  wdat_reg;               // Byte for data input
   reg  [7:0]  rdat_reg;               // Last byte read
   reg  [7:0]  sr_reg;                 // Last status byte
   reg         refused_reg;            // Order refused
   reg         plane_err_reg;          // Plane mismatch refused
   reg         parity_reg;             // Parity mismatch warning
   reg         ecc_seen_reg;           // ECC flag seen on source
   reg         intr_reg;               // Reset accepted in the first idle cycle after a program ends
   reg         prog_busy_reg;          // Program confirmed, not done
   // Step decode outputs
   reg  [2:0]  kind;
   reg  [7:0]  byte_val;

   // ****************************************************************
   // AXI write path
   // ****************************************************************
   wire wr_go = s_axi_awvalid & s_axi_wvalid & ~s_axi_bvalid;
   assign s_axi_awready = wr_go;
   assign s_axi_wready  = wr_go;
   wire wr_ctrl = wr_go & (s_axi_awaddr == `NCB_OFF_CTRL) & s_axi_wstrb[0];
   wire wr_stat = wr_go & (s_axi_awaddr == `NCB_OFF_STAT) & s_axi_wstrb[0];
   wire wr_map  = (s_axi_awaddr == `NCB_OFF_CTRL) | (s_axi_awaddr == `NCB_OFF_COL) |
                  (s_axi_awaddr == `NCB_OFF_ROW) | (s_axi_awaddr == `NCB_OFF_DATA) |
                  (s_axi_awaddr == `NCB_OFF_STAT);
   wire [3:0] new_op = s_axi_wdata[`NCB_CTRL_OP];
   // Only status reads, byte reads and reset may reach a busy device
   wire dev_ok = rb_n | (new_op == `NCB_OP_STATUS) | (new_op == `NCB_OP_STAT_ENH) |
                 (new_op == `NCB_OP_RD_BYTE) | (new_op == `NCB_OP_RESET);
   // Destination must share the source plane bit
   wire plane_bad = (new_op == `NCB_OP_CB_PROG) &
                    (row_reg[`NCB_PLANE_BIT] != src_row_reg[`NCB_PLANE_BIT]);
   // Raised pass voltage read only after an ECC flag
   wire hi_bad = (new_op == `NCB_OP_CB_RDHI) & ~ecc_seen_reg;
   wire op_bad = (new_op > `NCB_OP_RESET) | plane_bad | hi_bad;
   wire start  = wr_ctrl & (state_reg == S_IDLE) & dev_ok & ~op_bad;
   wire refuse = wr_ctrl & ~start;

   // Bus write response and plain registers
   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= OKAY;
         col_reg      <= 16'h0000;
         row_reg      <= 24'h000000;
         wdat_reg     <= 8'h00;
         wp_n         <= 1'b0;
      end else begin
         if (wr_go) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_map ? OKAY : SLVERR;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
         if (wr_ctrl)
            wp_n <= s_axi_wdata[`NCB_CTRL_WPN];
         if (wr_go && s_axi_awaddr == `NCB_OFF_COL)
            col_reg <= s_axi_wdata[15:0];
         if (wr_go && s_axi_awaddr == `NCB_OFF_ROW)
            row_reg <= s_axi_wdata[23:0];
         if (wr_go && s_axi_awaddr == `NCB_OFF_DATA)
            wdat_reg <= s_axi_wdata[7:0];
      end
   end

   // ****************************************************************
   // AXI read path
   // ****************************************************************
   assign s_axi_arready = ~s_axi_rvalid;
   wire [31:0] stat_word = {16'h0000, sr_reg, 1'b0, intr_reg, ecc_seen_reg, parity_reg,
                            plane_err_reg, refused_reg, rb_n, (state_reg != S_IDLE)};

   // Read data mux, registered
   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h00000000;
         s_axi_rresp  <= OKAY;
      end else if (s_axi_arvalid && !s_axi_rvalid) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp  <= OKAY;
         case (s_axi_araddr)
            `NCB_OFF_CTRL: s_axi_rdata <= {27'h0000000, wp_n, op_reg};
            `NCB_OFF_COL:  s_axi_rdata <= {16'h0000, col_reg};
            `NCB_OFF_ROW:  s_axi_rdata <= {8'h00, row_reg};
            `NCB_OFF_DATA: s_axi_rdata <= {24'h000000, rdat_reg};
            `NCB_OFF_STAT: s_axi_rdata <= stat_word;
            default: begin
               s_axi_rdata <= 32'h00000000;
               s_axi_rresp <= SLVERR;
            end
         endcase
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // ****************************************************************
   // Step decode: what each operation puts on the bus
   // ****************************************************************
   always @* begin
      kind     = K_DONE;
      byte_val = 8'h00;
      case (op_reg)
         `NCB_OP_CB_READ, `NCB_OP_CB_RDHI: begin
            case (step_reg)
               3'd0: begin kind = K_CMD; byte_val = `NCB_C_READ; end
               3'd1: begin kind = K_ADR; byte_val = col_reg[7:0]; end
               3'd2: begin kind = K_ADR; byte_val = col_reg[15:8]; end
               3'd3: begin kind = K_ADR; byte_val = row_reg[7:0]; end
               3'd4: begin kind = K_ADR; byte_val = row_reg[15:8]; end
               3'd5: begin kind = K_ADR; byte_val = row_reg[23:16]; end
               3'd6: begin
                  kind     = K_CMD;
                  byte_val = (op_reg == `NCB_OP_CB_RDHI) ? `NCB_C_CB_HIGH
                                                         : `NCB_C_CB_LOW;
               end
               3'd7: kind = K_WAIT;
               default: kind = K_DONE;
            endcase
         end
         `NCB_OP_CB_PROG: begin
            case (step_reg)
               3'd0: begin kind = K_CMD; byte_val = `NCB_C_CB_PROG; end
               3'd1: begin kind = K_ADR; byte_val = col_reg[7:0]; end
               3'd2: begin kind = K_ADR; byte_val = col_reg[15:8]; end
               3'd3: begin kind = K_ADR; byte_val = row_reg[7:0]; end
               3'd4: begin kind = K_ADR; byte_val = row_reg[15:8]; end
               3'd5: begin kind = K_ADR; byte_val = row_reg[23:16]; end
               default: kind = K_DONE;
            endcase
         end
         `NCB_OP_DATA_IN:
            if (step_reg == 3'd0) begin kind = K_DAT; byte_val = wdat_reg; end
         `NCB_OP_CONFIRM, `NCB_OP_RESET: begin
            case (step_reg)
               3'd0: begin
                  kind     = K_CMD;
                  byte_val = (op_reg == `NCB_OP_RESET) ? `NCB_C_RESET : `NCB_C_CONFIRM;
               end
               3'd1: kind = K_WAIT;
               default: kind = K_DONE;
            endcase
         end
         `NCB_OP_STATUS:
            case (step_reg)
               3'd0: begin kind = K_CMD; byte_val = `NCB_C_STATUS; end
               3'd1: kind = K_RD;
               default: kind = K_DONE;
            endcase
         `NCB_OP_STAT_ENH:
            case (step_reg)
               3'd0: begin kind = K_CMD; byte_val = `NCB_C_STAT_ENH; end
               3'd1: begin kind = K_ADR; byte_val = row_reg[7:0]; end
               3'd2: begin kind = K_ADR; byte_val = row_reg[15:8]; end
               3'd3: begin kind = K_ADR; byte_val = row_reg[23:16]; end
               3'd4: kind = K_RD;
               default: kind = K_DONE;
            endcase
         `NCB_OP_RD_BYTE:
            if (step_reg == 3'd0) kind = K_RD;
         `NCB_OP_RESUME:
            if (step_reg == 3'd0) begin kind = K_CMD; byte_val = `NCB_C_READ; end
         default: kind = K_DONE;
      endcase
   end

   // ****************************************************************
   // Pin sequencer
   // ****************************************************************
   always @(posedge aclk) begin
      if (!aresetn) begin
         state_reg     <= S_IDLE;
         op_reg        <= 4'h0;
         step_reg      <= 3'h0;
         ph_reg        <= 8'h00;
         ce_n          <= 1'b1;
         cle           <= 1'b0;
         ale           <= 1'b0;
         we_n          <= 1'b1;
         read_strobe_n <= 1'b1;
         io_out        <= 8'h00;
         io_oe         <= 1'b0;
         rdat_reg      <= 8'h00;
         src_row_reg   <= 24'h000000;
      end else begin
         case (state_reg)
            // Wait for an accepted order
            S_IDLE: begin
               ce_n <= 1'b1;
               if (start) begin
                  op_reg    <= new_op;
                  step_reg  <= 3'h0;
                  state_reg <= S_DEC;
                  if (new_op == `NCB_OP_CB_READ || new_op == `NCB_OP_CB_RDHI)
                     src_row_reg <= row_reg;
               end
            end
            // Set up the next bus cycle
            S_DEC: begin
               ce_n   <= 1'b0;
               ph_reg <= 8'h00;
               cle    <= (kind == K_CMD);
               ale    <= (kind == K_ADR);
               io_out <= byte_val;
               io_oe  <= (kind == K_CMD) | (kind == K_ADR) | (kind == K_DAT);
               case (kind)
                  K_CMD, K_ADR, K_DAT: begin
                     we_n      <= 1'b0;
                     state_reg <= S_WLO;
                  end
                  K_RD: begin
                     read_strobe_n <= 1'b0;
                     state_reg     <= S_RLO;
                  end
                  K_WAIT:  state_reg <= S_WB;
                  default: state_reg <= S_IDLE;
               endcase
            end
            // Write strobe low, then high
            S_WLO: begin
               ph_reg <= ph_reg + 8'h01;
               if (ph_reg == TWP_C - 8'h01) begin
                  we_n      <= 1'b1;
                  ph_reg    <= 8'h00;
                  state_reg <= S_WHI;
               end
            end
            S_WHI: begin
               ph_reg <= ph_reg + 8'h01;
               if (ph_reg == TWH_C - 8'h01) begin
                  cle       <= 1'b0;
                  ale       <= 1'b0;
                  io_oe     <= 1'b0;
                  step_reg  <= step_reg + 3'h1;
                  state_reg <= S_DEC;
               end
            end
            // Read strobe low; sample at its end
            S_RLO: begin
               ph_reg <= ph_reg + 8'h01;
               if (ph_reg == TRP_C - 8'h01) begin
                  rdat_reg      <= io_in;
                  read_strobe_n <= 1'b1;
                  ph_reg        <= 8'h00;
                  state_reg     <= S_RHI;
               end
            end
            S_RHI: begin
               ph_reg <= ph_reg + 8'h01;
               if (ph_reg == TREH_C - 8'h01) begin
                  step_reg  <= step_reg + 3'h1;
                  state_reg <= S_DEC;
               end
            end
            // Let busy assert, then wait for ready
            S_WB: begin
               ph_reg <= ph_reg + 8'h01;
               if (ph_reg == TWB_C - 8'h01)
                  state_reg <= S_WRB;
            end
            S_WRB:
               if (rb_n)
                  state_reg <= S_IDLE; // Wait is always the last step
            default: state_reg <= S_IDLE;
         endcase
      end
   end

   // ****************************************************************
   // Flags and status capture
   // ****************************************************************
   wire rd_done = (state_reg == S_RLO) && (ph_reg == TRP_C - 8'h01);
   wire is_stat = (op_reg == `NCB_OP_STATUS) | (op_reg == `NCB_OP_STAT_ENH) |
                  (op_reg == `NCB_OP_RD_BYTE);
   wire par_set = start & (new_op == `NCB_OP_CB_PROG) &
                  (row_reg[`NCB_PARITY_BIT] != src_row_reg[`NCB_PARITY_BIT]);
   wire [31:0] clr = wr_stat ? s_axi_wdata : 32'h00000000; // Write one to clear

   // Sticky flags; a set wins over a clear
   always @(posedge aclk) begin
      if (!aresetn) begin
         refused_reg   <= 1'b0;
         plane_err_reg <= 1'b0;
         parity_reg    <= 1'b0;
         ecc_seen_reg  <= 1'b0;
         intr_reg      <= 1'b0;
         prog_busy_reg <= 1'b0;
         sr_reg        <= 8'h00;
      end else begin
         refused_reg   <= refuse | (refused_reg & ~clr[`NCB_ST_REFUSED]);
         plane_err_reg <= (refuse & plane_bad) | (plane_err_reg & ~clr[`NCB_ST_PLANE]);
         parity_reg    <= par_set | (parity_reg & ~clr[`NCB_ST_PARITY]);
         // Status byte kept from status, enhanced status and byte reads, in any mode
         if (rd_done && is_stat) begin
            sr_reg       <= io_in & 8'hf9;
         end
         // ECC flag on a source read enables the raised read
         ecc_seen_reg <= (rd_done & is_stat & io_in[`NCB_SR_ECC]) |
                         (ecc_seen_reg & ~clr[`NCB_ST_ECC]);
         // Program is in flight from confirm to ready
         if (start && new_op == `NCB_OP_CONFIRM)
            prog_busy_reg <= 1'b1;
         else if (state_reg == S_IDLE && rb_n)
            prog_busy_reg <= 1'b0;
         // Reset in the first idle cycle after a program flags that page
         intr_reg <= (start & (new_op == `NCB_OP_RESET) & prog_busy_reg) |
                     (intr_reg & ~clr[`NCB_ST_INTR]);
      end
   end
endmodule // ncb_host

/* verilog/ncb_map.vh */
`ifndef NCB_MAP_VH
`define NCB_MAP_VH
// ****************************************************************
// Register offsets
// ****************************************************************
`define NCB_OFF_CTRL    5'h00
`define NCB_OFF_COL     5'h04
`define NCB_OFF_ROW     5'h08
`define NCB_OFF_DATA    5'h0c
`define NCB_OFF_STAT    5'h10
// ****************************************************************
// Control fields and operation codes
// ****************************************************************
`define NCB_CTRL_OP     3:0
`define NCB_CTRL_WPN    4
`define NCB_OP_CB_READ  4'h0
`define NCB_OP_CB_RDHI  4'h1
`define NCB_OP_CB_PROG  4'h2
`define NCB_OP_DATA_IN  4'h3
`define NCB_OP_CONFIRM  4'h4
`define NCB_OP_STATUS   4'h5
`define NCB_OP_STAT_ENH 4'h6
`define NCB_OP_RD_BYTE  4'h7
`define NCB_OP_RESUME   4'h8
`define NCB_OP_RESET    4'h9
// ****************************************************************
// Status register bits
// ****************************************************************
`define NCB_ST_ACTIVE   0
`define NCB_ST_RB       1
`define NCB_ST_REFUSED  2
`define NCB_ST_PLANE    3
`define NCB_ST_PARITY   4
`define NCB_ST_ECC      5
`define NCB_ST_INTR     6
`define NCB_ST_SR       15:8
`define NCB_SR_FAIL     0
`define NCB_SR_ECC      4
// ****************************************************************
// Flash command codes and address fields
// ****************************************************************
`define NCB_C_READ      8'h00
`define NCB_C_CB_LOW    8'h35
`define NCB_C_CB_HIGH   8'h36
`define NCB_C_CB_PROG   8'h85
`define NCB_C_CONFIRM   8'h10
`define NCB_C_STATUS    8'h70
`define NCB_C_STAT_ENH  8'h78
`define NCB_C_RESET     8'hff
`define NCB_PLANE_BIT   6
`define NCB_PARITY_BIT  0
// ****************************************************************
// Pin timing
// ****************************************************************
`define NCB_CLK_NS      10
`define NCB_TWP_NS      25
`define NCB_TWH_NS      15
`define NCB_TRP_NS      25
`define NCB_TREH_NS     15
`define NCB_TWB_NS      100
`define NCB_CYC(ns)     (((ns) + `NCB_CLK_NS - 1) / `NCB_CLK_NS)
`endif

/* verif/ncb_host_chk.sv */
`timescale 1ns/1ns
// ********
// Port checker
// ********
module ncb_host_chk (
   // Clock and reset
   input logic        aclk,
   input logic        aresetn,
   // Register bus
   input logic [4:0]  s_axi_awaddr,
   input logic        s_axi_awvalid,
   input logic        s_axi_awready,
   input logic [31:0] s_axi_wdata,
   input logic [3:0]  s_axi_wstrb,
   input logic [1:0]  s_axi_bresp,
   input logic        s_axi_bvalid,
   input logic        s_axi_bready,
   input logic        s_axi_arvalid,
   input logic        s_axi_rvalid,
   // Flash pins
   input logic        ce_n,
   input logic        cle,
   input logic        we_n,
   input logic        read_strobe_n,
   input logic        wp_n,
   input logic        rb_n,
   input logic [7:0]  io_out
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   wire wr_take = s_axi_awvalid && s_axi_awready;  // Write taken
   // Strobe shapes: three cycles low, two high
   sequence we_shape; !we_n [*3] ##1 we_n [*2]; endsequence
   sequence re_shape; !read_strobe_n [*3] ##1 read_strobe_n [*2]; endsequence
   wr_answer_a: assert property (wr_take |=> s_axi_bvalid)
      else $error("write not answered");
   rd_answer_a: assert property (s_axi_arvalid && !s_axi_rvalid |=> s_axi_rvalid)
      else $error("read not answered");
   resp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped");
   unmapped_err_a: assert property (wr_take && s_axi_awaddr[4:2] > 3'h4 |=> s_axi_bresp == 2'b10)
      else $error("unmapped write accepted");
   wp_follow_a: assert property (wr_take && s_axi_awaddr == 5'h00 && s_axi_wstrb[0]
      |=> wp_n == $past(s_axi_wdata[4])) else $error("protect pin stale");
   we_pulse_a: assert property ($fell(we_n) |-> we_shape)
      else $error("write strobe shape");
   re_pulse_a: assert property ($fell(read_strobe_n) |-> re_shape)
      else $error("read strobe shape");
   strobe_sel_a: assert property (!we_n || !read_strobe_n |-> !ce_n && (we_n || read_strobe_n))
      else $error("strobe without select");
   busy_cmd_a: assert property (!rb_n && cle && $fell(we_n) |-> io_out inside {8'h70, 8'h78, 8'hff})
      else $error("command while busy");
endmodule // ncb_host_chk
bind ncb_host ncb_host_chk chk (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
   .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
   .s_axi_wstrb(s_axi_wstrb), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
   .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_rvalid(s_axi_rvalid),
   .ce_n(ce_n), .cle(cle), .we_n(we_n), .read_strobe_n(read_strobe_n), .wp_n(wp_n),
   .rb_n(rb_n), .io_out(io_out));

/* verif/ncb_flash_model.sv */
`timescale 1ns/1ns
// ********
// Flash device model
// ********
module ncb_flash_model #(
   parameter int T_CB   = 40,  // Copy-back read busy, sub-plane time included
   parameter int T_PROG = 60,  // Program busy
   parameter int T_RST  = 8    // Reset busy
) (
   // Host-driven pins
   input logic        aclk,
   input logic        ce_n,
   input logic        cle,
   input logic        ale,
   input logic        we_n,
   input logic        read_strobe_n,
   input logic        wp_n,
   input logic [7:0]  io_out,
   // Device-driven pins
   output logic       rb_n,
   output logic [7:0] io_in
);
   logic [7:0] page [16];             // Data register, low columns only
   logic [7:0] cmd = 0, row0 = 0, last = 0;
   logic [3:0] col = 0;
   logic       st_mode = 0, hp = 0, ecc = 0;
   int         busy = 0, na = 0, prog_cnt = 0;
   wire  [7:0] st  = {wp_n, busy == 0, busy == 0, ecc, 4'h0};
   wire  [7:0] drv = st_mode ? st : page[col];
   assign rb_n  = (busy == 0);
   assign io_in = (!ce_n && !read_strobe_n) ? drv : ~last;  // Released bus flips
   // Internal timer
   always @(posedge aclk) if (busy > 0) busy <= busy - 1;
   // Bus cycles latched at write strobe rise
   always @(posedge we_n) if (!ce_n) begin
      if (cle && (busy == 0 || io_out inside {8'h70, 8'h78, 8'hff})) begin
         cmd = io_out;
         na = 0;
         st_mode = io_out inside {8'h70, 8'h78};
         if (io_out inside {8'h35, 8'h36}) begin
            hp = (io_out == 8'h36);
            ecc = row0[7];
            for (int i = 0; i < 16; i++) page[i] = row0 ^ 8'(i);
            busy = T_CB;
         end
         if (io_out == 8'h10) begin
            prog_cnt++;
            busy = T_PROG;
         end
         if (io_out == 8'hff) begin
            ecc = 0;
            busy = T_RST;
         end
      end else if (ale) begin
         if (na == 0) col = io_out[3:0];
         if (na == 2) row0 = io_out;
         na++;
      end else if (cmd == 8'h85) begin
         page[col] = io_out;
         col++;
      end
   end
   // Column advances per data read
   always @(posedge read_strobe_n) if (!ce_n) begin
      last = drv;
      if (!st_mode) col++;
   end
endmodule // ncb_flash_model

/* verif/ncb_host_tb.sv */
`timescale 1ns/1ns
`include "ncb_map.vh"
module ncb_host_tb;
   logic        aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0;
   logic        rready = 0;
   logic [4:0]  awaddr = 0, araddr = 0;
   logic [31:0] wdata = 0, d;
   logic [1:0]  r;
   wire         awready, wready, bvalid, rvalid, arready, ce_n, cle, ale, we_n, re_n;
   wire         wp_n, rb_n, io_oe;
   wire  [1:0]  bresp, rresp;
   wire  [31:0] rdata;
   wire  [7:0]  io_in, io_out;
   int          n_fail = 0, n_checks = 0, cyc = 0;
   ncb_host uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .ce_n(ce_n), .cle(cle), .ale(ale), .we_n(we_n), .read_strobe_n(re_n), .wp_n(wp_n),
      .rb_n(rb_n), .io_in(io_in), .io_out(io_out), .io_oe(io_oe));
   ncb_flash_model dev (.aclk(aclk), .ce_n(ce_n), .cle(cle), .ale(ale), .we_n(we_n),
      .read_strobe_n(re_n), .wp_n(wp_n), .io_out(io_out), .rb_n(rb_n), .io_in(io_in));
   initial forever #5 aclk = ~aclk;
   // Hang guard
   always @(posedge aclk) begin
      cyc++;
      if (cyc == 30000) begin
         n_fail++;
         report_and_stop;
      end
   end
   task automatic chk(input string nm, input logic [31:0] seen, exp);
      n_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("[ERR] %s exp %h seen %h", nm, exp, seen);
      end
   endtask
   // Bus write; lag delays the response ready
   task automatic wr(input logic [4:0] a, input logic [31:0] v, input int lag = 0);
      @(posedge aclk);
      awaddr <= a;
      wdata <= v;
      awvalid <= 1;
      wvalid <= 1;
      do @(posedge aclk); while (!awready);
      awvalid <= 0;
      wvalid <= 0;
      repeat (lag) @(posedge aclk);
      bready <= 1;
      do @(posedge aclk); while (!bvalid);
      r = bresp;
      bready <= 0;
   endtask
   task automatic rd(input logic [4:0] a);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1;
      rready <= 1;
      do @(posedge aclk); while (!arready);
      arvalid <= 0;
      do @(posedge aclk); while (!rvalid);
      d = rdata;
      r = rresp;
      rready <= 0;
   endtask
   // Start an operation and wait until the sequencer is idle
   task automatic op(input logic [3:0] c, input logic w = 1);
      wr(`NCB_OFF_CTRL, {27'h0, w, c});
      do rd(`NCB_OFF_STAT); while (d[0]);
   endtask
   task automatic t_regs;
      rd(`NCB_OFF_CTRL);
      chk("ctrl reset", d, 32'h0);
      wr(`NCB_OFF_COL, 32'h3, 2);
      rd(`NCB_OFF_COL);
      chk("col", d, 32'h3);
      rd(5'h14);
      chk("bad rresp", r, 32'h2);
      chk("bad rdata", d, 32'h0);
      wr(5'h18, 32'hffff_ffff);
      chk("bad bresp", r, 32'h2);
   endtask
   task automatic t_cb_read;
      wr(`NCB_OFF_ROW, 32'h81);
      op(`NCB_OP_CB_READ);
      chk("pass volt", dev.hp, 32'h0);
      op(`NCB_OP_RD_BYTE);
      rd(`NCB_OFF_DATA);
      chk("loaded", d, 32'h82);
      op(`NCB_OP_STATUS);
      rd(`NCB_OFF_STAT);
      chk("status", d[15:8], 32'hf0);
      chk("ecc seen", d[5], 32'h1);
      op(`NCB_OP_RD_BYTE);
      rd(`NCB_OFF_DATA);
      chk("held", d, 32'hf0);
      op(`NCB_OP_RESUME);
      op(`NCB_OP_RD_BYTE);
      rd(`NCB_OFF_DATA);
      chk("resumed", d, 32'h85);
      op(`NCB_OP_CB_RDHI);
      chk("raised volt", dev.hp, 32'h1);
      op(`NCB_OP_STAT_ENH);
      rd(`NCB_OFF_STAT);
      chk("enh status", d[15:8], 32'hf0);
   endtask
   task automatic t_prog;
      wr(`NCB_OFF_ROW, 32'h103);
      wr(`NCB_OFF_COL, 32'h5);
      op(`NCB_OP_CB_PROG);
      wr(`NCB_OFF_DATA, 32'ha5);
      op(`NCB_OP_DATA_IN);
      chk("early prog", dev.prog_cnt, 32'h0);
      op(`NCB_OP_CONFIRM);
      chk("prog", dev.prog_cnt, 32'h1);
      chk("patch", dev.page[5], 32'ha5);
      op(`NCB_OP_STATUS);
      rd(`NCB_OFF_STAT);
      chk("pass", d[15:8], 32'hf0);
   endtask
   task automatic t_plane;
      wr(`NCB_OFF_ROW, 32'h43);
      op(`NCB_OP_CB_PROG);
      rd(`NCB_OFF_STAT);
      chk("plane", d[3:2], 32'h3);
      chk("no cycles", dev.cmd, 32'h70);
      wr(`NCB_OFF_STAT, 32'hff);
      rd(`NCB_OFF_STAT);
      chk("w1c", d[6:2], 32'h0);
   endtask
   task automatic t_reset;
      op(`NCB_OP_RESET, 1'b0);
      op(`NCB_OP_STATUS, 1'b0);
      rd(`NCB_OFF_STAT);
      chk("rst wp", d[15:8], 32'h60);
      op(`NCB_OP_STATUS);
      rd(`NCB_OFF_STAT);
      chk("rst nowp", d[15:8], 32'he0);
   endtask
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   initial begin
      repeat (8) @(posedge aclk);
      aresetn <= 1;
      t_regs;
      t_cb_read;
      t_prog;
      t_plane;
      t_reset;
      report_and_stop;
   end
endmodule // ncb_host_tb
